/* common/mmp_consts.vh */
// Constants for the multi-match PWM unit: register offsets, field positions, reset values
// Assumes inclusion by the PWM design file only
`ifndef MMP_CONSTS_VH
`define MMP_CONSTS_VH

// Register offsets (byte addresses, one 32-bit word each)
`define MMP_OFF_IRQ_STAT 8'h00
`define MMP_OFF_TIMER_CTRL 8'h04
`define MMP_OFF_COUNT 8'h08
`define MMP_OFF_PRESCALE 8'h0C
`define MMP_OFF_PRESCALE_CNT 8'h10
`define MMP_OFF_MATCH_CTRL 8'h14
`define MMP_OFF_MATCH_BASE 8'h18
`define MMP_OFF_EDGE_CTRL 8'h34
`define MMP_OFF_RELEASE 8'h38
`define MMP_OFF_IRQ_MASK 8'h3C

// Timer control fields
`define MMP_TC_ENABLE 0
`define MMP_TC_RESET 1
`define MMP_TC_PWM_MODE 3

// Match control: three bits per match register
`define MMP_MC_IRQ 0
`define MMP_MC_RESET 1
`define MMP_MC_STOP 2

// Edge control fields
`define MMP_EC_DOUBLE_LSB 2
`define MMP_EC_OUT_EN_LSB 9

`define MMP_RST_WORD 32'h0000_0000
`define MMP_RST_CTRL 4'h0

`endif

/* src/mmp_pwm_unit.v */
// Multi-match PWM unit: prescaled 32-bit timer, seven match registers, six PWM outputs
// Assumes a register master on mclk that never waits and external loads on the PWM pins
//
// Contract
// [R1] Timer counts mclk through a programmable 32-bit prescaler into a 32-bit counter.
// [R2] Seven match registers drive six single-edge or three double-edge outputs, or mixed.
// [R3] Cycle-period match clears the counter and sets the PWM repetition rate.
// [R4] Single-edge outputs go high at each cycle start on the period match.
// [R5] Each single-edge output uses one more match register for its falling edge.
// [R6] A single-edge output programmed constant low is not raised at cycle start.
// [R7] Double-edge outputs use two matches: rise then fall positive, else negative.
// [R8] Both double-edge edges may sit at any count within the cycle.
// [R9] All PWM outputs share one repetition rate from the cycle-period match.
// [R10] Any count value is accepted for pulse period and pulse width.
// [R11] Each match independently may interrupt, stop or reset the timer.
// [R12] Released match values take effect only in step with the pulse outputs.
// [R13] Without PWM mode the unit is a plain match timer; outputs undriven.
// [R14] Released values load into active compares when the period match resets the counter.
// [R15] One sticky interrupt flag per match register, cleared by writing one.
//
// The implementer's own choices: the register offsets and the plain strobed port.
`include "mmp_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module mmp_pwm_unit #(
	parameter NUM_MATCH = 7,
	parameter CNT_W = 32
) (
	input wire mclk,
	input wire reset,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	output wire irq,
	output reg [6:1] pwm_out,
	output reg [6:1] pwm_oe_n
);
	localparam NM = NUM_MATCH;

	reg [CNT_W-1:0] count_q;
	reg [31:0] prescale_q;
	reg [31:0] pre_cnt_q;
	reg [3:0] timer_ctrl_q;
	reg [3*NM-1:0] match_ctrl_q;
	reg [CNT_W-1:0] shadow_q [0:NM-1];
	reg [CNT_W-1:0] active_q [0:NM-1];
	reg [NM-1:0] release_q;
	reg [NM-1:0] irq_stat_q;
	reg [NM-1:0] irq_mask_q;
	reg [6:2] dbl_sel_q;
	reg [6:1] out_en_q;
	reg [6:1] level_q;
	// Output 1 can only be single-edge
	wire [6:1] dbl_all = {dbl_sel_q, 1'b0};

	wire counting = timer_ctrl_q[`MMP_TC_ENABLE] & ~timer_ctrl_q[`MMP_TC_RESET];
	wire pwm_mode = timer_ctrl_q[`MMP_TC_PWM_MODE];
	wire tick = counting && (pre_cnt_q == prescale_q); // [R1]

	// Match flags on the tick that the counter reaches each active compare
	reg [NM-1:0] hit;
	integer i;
	always @* begin
		for (i = 0; i < NM; i = i + 1) begin
			hit[i] = tick && (count_q == active_q[i]); // [R10]
		end
	end

	reg any_reset;
	reg any_stop;
	integer j;
	always @* begin
		any_reset = 1'b0;
		any_stop = 1'b0;
		for (j = 0; j < NM; j = j + 1) begin
			any_reset = any_reset | (hit[j] & match_ctrl_q[3*j+`MMP_MC_RESET]); // [R11]
			any_stop = any_stop | (hit[j] & match_ctrl_q[3*j+`MMP_MC_STOP]); // [R11]
		end
	end

	// In PWM mode the period match always restarts the cycle
	wire period_hit = hit[0];
	wire cycle_restart = any_reset | (pwm_mode & period_hit); // [R3] [R9]

	wire wr_ctrl = reg_wr && (reg_addr == `MMP_OFF_TIMER_CTRL);
	wire wr_mstat = reg_wr && (reg_addr == `MMP_OFF_IRQ_STAT);
	wire [7:0] match_idx = (reg_addr - `MMP_OFF_MATCH_BASE) >> 2;
	wire in_match = (reg_addr >= `MMP_OFF_MATCH_BASE) && (reg_addr < `MMP_OFF_EDGE_CTRL);

	// Prescaler and counter
	always @(posedge mclk) begin
		if (reset) begin
			pre_cnt_q <= `MMP_RST_WORD;
			count_q <= {CNT_W{1'b0}};
		end else if (timer_ctrl_q[`MMP_TC_RESET]) begin
			pre_cnt_q <= `MMP_RST_WORD;
			count_q <= {CNT_W{1'b0}};
		end else if (reg_wr && reg_addr == `MMP_OFF_COUNT) begin
			count_q <= reg_wdata[CNT_W-1:0];
		end else if (counting) begin
			if (tick) begin
				pre_cnt_q <= `MMP_RST_WORD; // [R1]
				if (cycle_restart) begin
					count_q <= {CNT_W{1'b0}}; // [R3]
				end else begin
					count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1}; // [R1]
				end
			end else begin
				pre_cnt_q <= pre_cnt_q + 32'h0000_0001;
			end
		end
	end

	// Control registers; a stop match clears the enable bit
	always @(posedge mclk) begin
		if (reset) begin
			timer_ctrl_q <= `MMP_RST_CTRL;
		end else if (wr_ctrl) begin
			timer_ctrl_q <= reg_wdata[3:0];
		end else if (any_stop) begin
			timer_ctrl_q[`MMP_TC_ENABLE] <= 1'b0; // [R11]
		end
	end

	always @(posedge mclk) begin
		if (reset) begin
			prescale_q <= `MMP_RST_WORD;
			match_ctrl_q <= {3*NM{1'b0}};
			irq_mask_q <= {NM{1'b0}};
			dbl_sel_q <= 5'h00;
			out_en_q <= 6'h00;
		end else if (reg_wr) begin
			case (reg_addr)
				`MMP_OFF_PRESCALE: prescale_q <= reg_wdata;
				`MMP_OFF_MATCH_CTRL: match_ctrl_q <= reg_wdata[3*NM-1:0];
				`MMP_OFF_IRQ_MASK: irq_mask_q <= reg_wdata[NM-1:0];
				`MMP_OFF_EDGE_CTRL: begin
					dbl_sel_q <= reg_wdata[`MMP_EC_DOUBLE_LSB+4:`MMP_EC_DOUBLE_LSB];
					out_en_q <= reg_wdata[`MMP_EC_OUT_EN_LSB+5:`MMP_EC_OUT_EN_LSB];
				end
				default: ;
			endcase
		end
	end

	// Shadow and active match values
	integer k;
	always @(posedge mclk) begin
		if (reset) begin
			for (k = 0; k < NM; k = k + 1) begin
				shadow_q[k] <= {CNT_W{1'b0}};
				active_q[k] <= {CNT_W{1'b0}};
			end
			release_q <= {NM{1'b0}};
		end else begin
			for (k = 0; k < NM; k = k + 1) begin
				if (reg_wr && in_match && match_idx == k) begin
					shadow_q[k] <= reg_wdata[CNT_W-1:0];
				end
				if (!pwm_mode) begin
					// Plain timer: compares follow writes directly
					if (reg_wr && in_match && match_idx == k) begin
						active_q[k] <= reg_wdata[CNT_W-1:0]; // [R13]
					end
				end else if (tick && cycle_restart && release_q[k]) begin
					active_q[k] <= shadow_q[k]; // [R12] [R14]
				end
			end
			if (pwm_mode && tick && cycle_restart) begin
				// Release written during the restart cycle survives to the next cycle
				release_q <= (reg_wr && reg_addr == `MMP_OFF_RELEASE) ? reg_wdata[NM-1:0] : {NM{1'b0}}; // [R12]
			end else if (reg_wr && reg_addr == `MMP_OFF_RELEASE) begin
				release_q <= release_q | reg_wdata[NM-1:0]; // [R12]
			end
		end
	end

	// Sticky match flags, set wins over write-one-to-clear
	integer m;
	always @(posedge mclk) begin
		if (reset) begin
			irq_stat_q <= {NM{1'b0}};
		end else begin
			for (m = 0; m < NM; m = m + 1) begin
				if (hit[m] && match_ctrl_q[3*m+`MMP_MC_IRQ]) begin
					irq_stat_q[m] <= 1'b1; // [R15] [R11]
				end else if (wr_mstat && reg_wdata[m]) begin
					irq_stat_q[m] <= 1'b0; // [R15]
				end
			end
		end
	end
	assign irq = |(irq_stat_q & irq_mask_q);

	// Output levels: single edge sets on period, clears on own match; double uses n-1 and n
	integer n;
	always @(posedge mclk) begin
		if (reset) begin
			level_q <= 6'h00;
		end else if (!pwm_mode) begin
			level_q <= 6'h00; // [R13]
		end else begin
			for (n = 1; n <= 6; n = n + 1) begin
				if (dbl_all[n]) begin
					if (hit[n-1]) begin
						level_q[n] <= 1'b1; // [R7] [R8]
					end
					if (hit[n]) begin
						level_q[n] <= 1'b0; // [R7] [R8]
					end
				end else begin
					if (hit[n]) begin
						level_q[n] <= 1'b0; // [R5]
					end else if (period_hit && active_q[n] != {CNT_W{1'b0}}) begin
						level_q[n] <= 1'b1; // [R4] [R6]
					end
				end
			end
		end
	end

	// Pins: oe_n low while driven, only in PWM mode and with output enabled
	always @(posedge mclk) begin
		if (reset) begin
			pwm_out <= 6'h00;
			pwm_oe_n <= 6'h3F;
		end else begin
			pwm_out <= level_q; // [R2]
			pwm_oe_n <= ~(out_en_q & {6{pwm_mode}}); // [R13]
		end
	end

	// Read data one cycle after the read strobe
	integer r;
	reg [31:0] rd_d;
	always @* begin
		rd_d = 32'h0000_0000;
		case (reg_addr)
			`MMP_OFF_IRQ_STAT: rd_d[NM-1:0] = irq_stat_q;
			`MMP_OFF_TIMER_CTRL: rd_d[3:0] = timer_ctrl_q;
			`MMP_OFF_COUNT: rd_d[CNT_W-1:0] = count_q;
			`MMP_OFF_PRESCALE: rd_d = prescale_q;
			`MMP_OFF_PRESCALE_CNT: rd_d = pre_cnt_q;
			`MMP_OFF_MATCH_CTRL: rd_d[3*NM-1:0] = match_ctrl_q;
			`MMP_OFF_EDGE_CTRL: begin
				rd_d[`MMP_EC_DOUBLE_LSB+4:`MMP_EC_DOUBLE_LSB] = dbl_sel_q;
				rd_d[`MMP_EC_OUT_EN_LSB+5:`MMP_EC_OUT_EN_LSB] = out_en_q;
			end
			`MMP_OFF_RELEASE: rd_d[NM-1:0] = release_q;
			`MMP_OFF_IRQ_MASK: rd_d[NM-1:0] = irq_mask_q;
			default: begin
				for (r = 0; r < NM; r = r + 1) begin
					if (in_match && match_idx == r) begin
						rd_d[CNT_W-1:0] = shadow_q[r];
					end
				end
			end
		endcase
	end

	always @(posedge mclk) begin
		if (reset) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= rd_d;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule // mmp_pwm_unit

`default_nettype wire

/* bench/mmp_load_model.sv */
// Load on the PWM pins: pull-down when released, measures period and high time
// Assumes the PWM unit's clock
`timescale 1ns/1ps
`default_nettype none
module mmp_load_model (
	input wire logic mclk,
	input wire logic [6:1] pwm_out,
	input wire logic [6:1] pwm_oe_n,
	output logic [6:1] pin
);
	logic [6:1] pin_q = 6'h00;
	int run[6:1];
	int hi[6:1];
	int period[6:1];
	int width[6:1];
	// Released pin falls to the pull-down level
	assign pin = pwm_out & ~pwm_oe_n;
	always @(posedge mclk) begin
		pin_q <= pin;
		for (int n = 1; n <= 6; n++) begin
			if (pin[n] && !pin_q[n]) begin
				period[n] <= run[n];
				width[n] <= hi[n];
				run[n] <= 1;
				hi[n] <= 1;
			end else begin
				run[n] <= run[n] + 1;
				hi[n] <= hi[n] + int'(pin[n]);
			end
		end
	end
endmodule // mmp_load_model
`default_nettype wire

/* bench/mmp_pwm_unit_sva.sv */
// Checker for the register port, interrupt masking and pin enables
// Assumes one clock and a synchronous reset
`timescale 1ns/1ps
`default_nettype none
module mmp_pwm_sva (
	input wire mclk,
	input wire reset,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire irq,
	input wire [6:1] pwm_out,
	input wire [6:1] pwm_oe_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	wire oe_wr = reg_wr && (reg_addr == 8'h04 || reg_addr == 8'h34);
	logic mask_off_q;
	always @(posedge mclk)
		if (reset)
			mask_off_q <= 1'b1;
		else if (reg_wr && reg_addr == 8'h3C)
			mask_off_q <= (reg_wdata[6:0] == 7'h0);
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("rdata not idle");
	AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == 32'h0) else $error("unmapped");
	AST_PRESCALE_RB: assert property (
		reg_wr && reg_addr == 8'h0C ##2 reg_rd && reg_addr == 8'h0C |=> reg_rdata == $past(reg_wdata, 3))
		else $error("prescale readback");
	AST_MATCH_RB: assert property (
		reg_wr && reg_addr inside {[8'h18:8'h30]} ##2 reg_rd && reg_addr == $past(reg_addr, 2)
		|=> reg_rdata == $past(reg_wdata, 3)) else $error("match readback");
	AST_OE_NO_PWM: assert property (
		reg_wr && reg_addr == 8'h04 && !reg_wdata[3] |=> ##1 pwm_oe_n == 6'h3F) else $error("driven");
	AST_OE_NO_EN: assert property (
		reg_wr && reg_addr == 8'h34 && reg_wdata[14:9] == 6'h0 |=> ##1 pwm_oe_n == 6'h3F) else $error("driven");
	AST_OE_QUIET: assert property (!$past(oe_wr, 2) |-> $stable(pwm_oe_n)) else $error("enable moved");
	AST_IRQ_MASKED: assert property (mask_off_q |-> !irq) else $error("masked irq");
endmodule // mmp_pwm_sva
bind mmp_pwm_unit mmp_pwm_sva u_sva (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n));
`default_nettype wire

/* bench/tb_top.sv */
// Testbench for the PWM unit: register tasks, pin timing through the load model
// Assumes the checker is bound to the unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic mclk = 0;
	logic reset = 1;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	wire [31:0] reg_rdata;
	wire irq;
	wire [6:1] pwm_out;
	wire [6:1] pwm_oe_n;
	wire [6:1] pin;
	int fails = 0;
	int compares = 0;
	int mv[7] = '{9, 3, 0, 2, 7, 5, 1};
	initial forever #12.5 mclk = ~mclk;
	mmp_pwm_unit dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n));
	mmp_load_model load (.mclk(mclk), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .pin(pin));
	task automatic check(string name, logic [31:0] exp, logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		// Let the register update settle before any compare
		#1;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] exp, string name);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 check(name, exp, reg_rdata);
	endtask
	task automatic pwm(int n, int per, int hi);
		repeat (30) @(posedge mclk);
		check("period", per, load.period[n]);
		check("width", hi, load.width[n]);
	endtask
	task final_report;
		$display("comparisons %0d, mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		wr(8'h04, 32'h0);
		rd(8'h40, 32'h0, "unmapped");
		wr(8'h0C, 32'h1234_5678);
		rd(8'h0C, 32'h1234_5678, "prescale");
		wr(8'h0C, 32'h0);
		for (int m = 0; m < 7; m++)
			wr(8'(8'h18 + 4 * m), mv[m]);
		// Outputs 4 and 6 double-edge, 5 left released
		wr(8'h34, 32'h0000_5E50);
		wr(8'h14, 32'h1);
		wr(8'h3C, 32'h1);
		wr(8'h04, 32'h9);
		// Pin enables are registered one cycle after the mode write
		@(posedge mclk);
		#1;
		check("oe_n", 6'h10, pwm_oe_n);
		pwm(1, 10, 4);
		pwm(3, 10, 3);
		pwm(2, 0, 0);
		pwm(4, 10, 5);
		pwm(6, 10, 6);
		check("irq", 1, irq);
		wr(8'h3C, 32'h0);
		check("irq", 0, irq);
		wr(8'h3C, 32'h1);
		check("irq", 1, irq);
		wr(8'h1C, 32'h5);
		rd(8'h1C, 32'h5, "shadow");
		pwm(1, 10, 4);
		wr(8'h38, 32'h2);
		pwm(1, 10, 6);
		wr(8'h14, 32'h5);
		repeat (12) @(posedge mclk);
		rd(8'h04, 32'h8, "ctrl");
		wr(8'h00, 32'h7F);
		check("irq", 0, irq);
		wr(8'h34, 32'h0);
		repeat (2) @(posedge mclk);
		check("pins", 6'h0, pin);
		final_report;
	end
endmodule // tb_top
`default_nettype wire
